// ===== rtl/audlk_defines.vh
`ifndef AUDLK_DEFINES_VH
`define AUDLK_DEFINES_VH

// ==========================================================================
// Device register map (word index; byte address is four times the index)
`define AUDLK_DEV_AW          24
`define AUDLK_GCTL_IDX        20'h00008
`define AUDLK_PRES_IDX        20'h0000e
`define AUDLK_IC_IDX          20'h00060
`define AUDLK_IR_IDX          20'h00064
`define AUDLK_ICS_IDX         20'h00068
`define AUDLK_CONTROLLER_LINK_CONTROL_IDX        20'h00c84
`define AUDLK_EM1_IDX         20'h01000
`define AUDLK_WAKE_IDX        20'h65f10
`define AUDLK_FREQ_IDX        20'h65f00
`define AUDLK_PINB_IDX        20'h65f04

// ==========================================================================
// Device field positions and values
`define AUDLK_BCLK_LSB        3
`define AUDLK_EARLY_LSB       11
`define AUDLK_TMODE_LSB       14
`define AUDLK_PINB_EN         32'h80000000
`define AUDLK_PINB_OFF        32'h00000000
`define AUDLK_WAKE_INIT       32'h00008000
`define AUDLK_SLEEP_BIT       14
`define AUDLK_GCTL_RUN        32'h00000001
`define AUDLK_ICS_BUSY_BIT    0
`define AUDLK_ICS_VALID_BIT   1
`define AUDLK_ICS_LAUNCH      32'h00000003
`define AUDLK_ICS_FORCE_IDLE  32'h00000000
`define AUDLK_TMODE_4T        2'h0
`define AUDLK_TMODE_8T        2'h1
`define AUDLK_PULL_FIRST      2'h1
`define AUDLK_PULL_LATER      2'h0
`define AUDLK_GETID_LOW       28'h00f0000

// ==========================================================================
// Timing
`define AUDLK_CLK_MHZ         25
`define AUDLK_WAKE_MS         50
`define AUDLK_WAKE_CYC        21'd1250000
`define AUDLK_ICB_US          50
`define AUDLK_ICB_CYC         21'd1250
`define AUDLK_LINK_EDGES      3'h4

// ==========================================================================
// Host register map (byte addresses on the software APB)
`define AUDLK_R_CTRL          8'h00
`define AUDLK_R_STAT          8'h04
`define AUDLK_R_VERB          8'h08
`define AUDLK_R_RESP          8'h0c
`define AUDLK_R_VID           8'h10
`define AUDLK_R_EXPID         8'h14
`define AUDLK_R_TLEN          8'h18
`define AUDLK_R_TBL           8'h40
`define AUDLK_CTRL_MASK       32'h00003e0c
`define AUDLK_CTRL_RESET      32'h00000800
`define AUDLK_TBL_DEPTH       16

`endif

// ===== rtl/audlk_host.v
// Functional notes
// - Controller and codec get identical clock/mode settings; power-up rewrites only the codec frequency register
// - Frequency settings written before pin buffer
// - Controller link setup via 0xc84 and 0x1000
// - Reprogram frequency right after power-domain up
// - Clear pin buffer bit 31 after power-off
// - Stepping picks 4T/pull 1 or 8T/pull 0
// - Each command is one 32-bit word
// - Wait 50 ms for codec reset exit
// - Busy bit must read zero before command
// - Command at 60h, codec address in 31:28
// - Writing 11b launches the held command
// - Busy clears; force zero after 50 us
// - Identity read with get-parameter 200F0000h
// - Table verbs sent one at a time
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "audlk_defines.vh"

module audlk_host #(
  parameter [20:0] WAKE_WAIT_CYC = `AUDLK_WAKE_CYC,
  parameter [20:0] SLEEP_TMO_CYC = `AUDLK_WAKE_CYC
) (
  input  wire                     CLOCK,
  input  wire                     RSTN,
  input  wire                     LINK_BCLK,
  input  wire                     CODEC_POWER_ON,
  input  wire                     S_PSEL,
  input  wire                     S_PENABLE,
  input  wire                     S_PWRITE,
  input  wire [7:0]               S_PADDR,
  input  wire [31:0]              S_PWDATA,
  output reg  [31:0]              S_PRDATA,
  output wire                     S_PREADY,
  output reg                      S_PSLVERR,
  output reg                      M_PSEL,
  output reg                      M_PENABLE,
  output reg                      M_PWRITE,
  output reg  [`AUDLK_DEV_AW-1:0] M_PADDR,
  output reg  [31:0]              M_PWDATA,
  input  wire [31:0]              M_PRDATA,
  input  wire                     M_PREADY
);

  // ==========================================================================
  // States and verb phases
  localparam [4:0] S_IDLE  = 5'h00;
  localparam [4:0] S_FREQ  = 5'h01;
  localparam [4:0] S_CONTROLLER_LINK_CONTROL  = 5'h02;
  localparam [4:0] S_EM1   = 5'h03;
  localparam [4:0] S_PINB  = 5'h04;
  localparam [4:0] S_LINK  = 5'h05;
  localparam [4:0] S_GCTL  = 5'h06;
  localparam [4:0] S_GRD   = 5'h07;
  localparam [4:0] S_WAKE  = 5'h08;
  localparam [4:0] S_WAIT  = 5'h09;
  localparam [4:0] S_SLEEP = 5'h0a;
  localparam [4:0] S_PRES  = 5'h0b;
  localparam [4:0] S_VCHK  = 5'h0c;
  localparam [4:0] S_VWR   = 5'h0d;
  localparam [4:0] S_VGO   = 5'h0e;
  localparam [4:0] S_VPOLL = 5'h0f;
  localparam [4:0] S_VCLR  = 5'h10;
  localparam [4:0] S_VRESP = 5'h11;
  localparam [4:0] S_VNEXT = 5'h12;
  localparam [4:0] S_PDOWN = 5'h13;

  localparam [1:0] PH_ID   = 2'h0;
  localparam [1:0] PH_TBL  = 2'h1;
  localparam [1:0] PH_ONE  = 2'h2;

  // ==========================================================================
  // Functions
  // Device word index to APB byte address
  function [`AUDLK_DEV_AW-1:0] dev_addr;
    input [19:0] idx;
    begin
      dev_addr = {2'b00, idx, 2'b00};
    end
  endfunction

  // Shared layout keeps controller and codec settings identical
  function [31:0] link_word;
    input [1:0] bclk;
    input [1:0] tmode;
    input [1:0] pull;
    begin
      link_word = 32'h0;
      link_word[`AUDLK_BCLK_LSB +: 2]  = bclk;
      link_word[`AUDLK_TMODE_LSB +: 2] = tmode;
      link_word[`AUDLK_EARLY_LSB +: 2] = pull;
    end
  endfunction

  // ==========================================================================
  // Declarations
  reg  [31:0] ctrl_cfg;
  reg  [31:0] verb_reg;
  reg  [31:0] exp_id;
  reg  [4:0]  tbl_len;
  reg  [31:0] tbl [0:`AUDLK_TBL_DEPTH-1];
  reg  [4:0]  state;
  reg  [1:0]  phase;
  reg  [3:0]  tbl_idx;
  reg  [20:0] tmr;
  reg  [2:0]  bclk_edges;
  reg         repower;
  reg         seq_done;
  reg         seq_err;
  reg         resp_ok;
  reg         id_miss;
  reg         link_seen;
  reg  [3:0]  presence;
  reg  [31:0] resp_reg;
  reg  [31:0] vid_reg;
  reg         start_p;
  reg         verb_p;
  reg         pwr_up_p;
  reg         pwr_dn_p;
  reg         bclk_s1;
  reg         bclk_s2;
  reg         bclk_s3;
  reg         pwr_s1;
  reg         pwr_s2;
  reg         pwr_s3;
  reg         req_on;
  reg         req_wr;
  reg  [19:0] req_idx;
  reg  [31:0] req_data;
  reg  [31:0] rd_mux;
  reg         rd_err;
  wire        bus_done;
  wire        sw_setup;
  wire        sw_wr;
  wire        wr_ctrl;
  wire [1:0]  tmode_sel;
  wire [1:0]  pull_sel;
  wire [31:0] cfg_word;
  wire [31:0] verb_word;
  wire        bclk_rise;
  wire        pwr_rise;
  wire        pwr_fall;
  integer     i;

  assign bus_done  = M_PSEL & M_PENABLE & M_PREADY;
  assign S_PREADY  = 1'b1;
  assign sw_setup  = S_PSEL & ~S_PENABLE;
  assign sw_wr     = S_PSEL & S_PENABLE & S_PWRITE;
  assign wr_ctrl   = sw_wr & (S_PADDR == `AUDLK_R_CTRL);
  // Stepping select fixes mode and pull-in as a pair
  assign tmode_sel = ctrl_cfg[9] ? `AUDLK_TMODE_8T : `AUDLK_TMODE_4T;
  assign pull_sel  = ctrl_cfg[9] ? `AUDLK_PULL_LATER : `AUDLK_PULL_FIRST;
  assign cfg_word  = link_word(ctrl_cfg[3:2], tmode_sel, pull_sel);
  // Identity query goes to the configured codec address
  assign verb_word = (phase == PH_ID)  ? {ctrl_cfg[13:10], `AUDLK_GETID_LOW} :
                     (phase == PH_TBL) ? tbl[tbl_idx] : verb_reg;
  assign bclk_rise = bclk_s2 & ~bclk_s3;
  assign pwr_rise  = pwr_s2 & ~pwr_s3;
  assign pwr_fall  = ~pwr_s2 & pwr_s3;

  // ==========================================================================
  // Pin synchronisers; first stage feeds only the second
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_s3 <= 1'b0;
      pwr_s1  <= 1'b0;
      pwr_s2  <= 1'b0;
      pwr_s3  <= 1'b0;
    end else begin
      bclk_s1 <= LINK_BCLK;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      pwr_s1  <= CODEC_POWER_ON;
      pwr_s2  <= pwr_s1;
      pwr_s3  <= pwr_s2;
    end
  end

  // ==========================================================================
  // Device access decode per state
  always @* begin
    req_on   = 1'b1;
    req_wr   = 1'b1;
    req_idx  = `AUDLK_ICS_IDX;
    req_data = 32'h0;
    case (state)
      S_FREQ: begin
        req_idx  = `AUDLK_FREQ_IDX;
        req_data = cfg_word;
      end
      S_CONTROLLER_LINK_CONTROL: begin
        req_idx  = `AUDLK_CONTROLLER_LINK_CONTROL_IDX;
        req_data = cfg_word;
      end
      S_EM1: begin
        req_idx  = `AUDLK_EM1_IDX;
        req_data = cfg_word;
      end
      S_PINB: begin
        req_idx  = `AUDLK_PINB_IDX;
        req_data = `AUDLK_PINB_EN;
      end
      S_GCTL: begin
        req_idx  = `AUDLK_GCTL_IDX;
        req_data = `AUDLK_GCTL_RUN;
      end
      S_GRD: begin
        req_idx = `AUDLK_GCTL_IDX;
        req_wr  = 1'b0;
      end
      S_WAKE: begin
        req_idx  = `AUDLK_WAKE_IDX;
        req_data = `AUDLK_WAKE_INIT;
      end
      S_SLEEP: begin
        req_idx = `AUDLK_WAKE_IDX;
        req_wr  = 1'b0;
      end
      S_PRES: begin
        req_idx = `AUDLK_PRES_IDX;
        req_wr  = 1'b0;
      end
      S_VCHK, S_VPOLL: begin
        req_wr = 1'b0;
      end
      S_VWR: begin
        req_idx  = `AUDLK_IC_IDX;
        req_data = verb_word;
      end
      S_VGO: begin
        req_data = `AUDLK_ICS_LAUNCH;
      end
      S_VCLR: begin
        req_data = `AUDLK_ICS_FORCE_IDLE;
      end
      S_VRESP: begin
        req_idx = `AUDLK_IR_IDX;
        req_wr  = 1'b0;
      end
      S_PDOWN: begin
        req_idx  = `AUDLK_PINB_IDX;
        req_data = `AUDLK_PINB_OFF;
      end
      default: begin
        req_on = 1'b0;
        req_wr = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // APB master: setup, access until pready, then release
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      M_PSEL    <= 1'b0;
      M_PENABLE <= 1'b0;
      M_PWRITE  <= 1'b0;
      M_PADDR   <= {`AUDLK_DEV_AW{1'b0}};
      M_PWDATA  <= 32'h0;
    end else if (bus_done) begin
      M_PSEL    <= 1'b0;
      M_PENABLE <= 1'b0;
    end else if (M_PSEL) begin
      M_PENABLE <= 1'b1;
    end else if (req_on) begin
      M_PSEL   <= 1'b1;
      M_PWRITE <= req_wr;
      M_PADDR  <= dev_addr(req_idx);
      M_PWDATA <= req_data;
    end
  end

  // ==========================================================================
  // Bring-up and verb sequencer
  // Pending events: a set in the clearing cycle wins
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state      <= S_IDLE;
      phase      <= PH_ID;
      tbl_idx    <= 4'h0;
      tmr        <= 21'h0;
      bclk_edges <= 3'h0;
      repower    <= 1'b0;
      seq_done   <= 1'b0;
      seq_err    <= 1'b0;
      resp_ok    <= 1'b0;
      id_miss    <= 1'b0;
      link_seen  <= 1'b0;
      presence   <= 4'h0;
      resp_reg   <= 32'h0;
      vid_reg    <= 32'h0;
      start_p    <= 1'b0;
      verb_p     <= 1'b0;
      pwr_up_p   <= 1'b0;
      pwr_dn_p   <= 1'b0;
    end else begin
      tmr <= tmr + 21'h1;
      case (state)
        S_IDLE: begin
          if (pwr_dn_p) begin
            pwr_dn_p <= 1'b0;
            state    <= S_PDOWN;
          end else if (pwr_up_p) begin
            pwr_up_p <= 1'b0;
            repower  <= 1'b1;
            state    <= S_FREQ;
          end else if (start_p) begin
            start_p    <= 1'b0;
            repower    <= 1'b0;
            seq_done   <= 1'b0;
            seq_err    <= 1'b0;
            resp_ok    <= 1'b0;
            id_miss    <= 1'b0;
            vid_reg    <= 32'h0;
            bclk_edges <= 3'h0;
            state      <= S_FREQ;
          end else if (verb_p) begin
            verb_p   <= 1'b0;
            seq_done <= 1'b0;
            seq_err  <= 1'b0;
            resp_ok  <= 1'b0;
            phase    <= PH_ONE;
            state    <= S_VCHK;
          end
        end
        S_FREQ:
          if (bus_done) state <= repower ? S_IDLE : S_CONTROLLER_LINK_CONTROL;
        S_CONTROLLER_LINK_CONTROL:
          if (bus_done) state <= S_EM1;
        S_EM1:
          if (bus_done) state <= S_PINB;
        S_PINB:
          if (bus_done) state <= S_LINK;
        // Link bit clock must be seen toggling before reset release
        S_LINK: begin
          if (bclk_rise && bclk_edges != `AUDLK_LINK_EDGES)
            bclk_edges <= bclk_edges + 3'h1;
          if (bclk_edges == `AUDLK_LINK_EDGES) begin
            link_seen <= 1'b1;
            state     <= S_GCTL;
          end
        end
        S_GCTL:
          if (bus_done) state <= S_GRD;
        S_GRD:
          if (bus_done) state <= M_PRDATA[0] ? S_WAKE : S_GCTL;
        S_WAKE:
          if (bus_done) begin
            tmr   <= 21'h0;
            state <= S_WAIT;
          end
        S_WAIT:
          if (tmr >= WAKE_WAIT_CYC - 21'h1) begin
            tmr   <= 21'h0;
            state <= S_SLEEP;
          end
        S_SLEEP:
          if (bus_done) begin
            if (!M_PRDATA[`AUDLK_SLEEP_BIT]) begin
              state <= S_PRES;
            end else if (tmr >= SLEEP_TMO_CYC) begin
              seq_err  <= 1'b1;
              seq_done <= 1'b1;
              state    <= S_IDLE;
            end
          end
        S_PRES:
          if (bus_done) begin
            presence <= M_PRDATA[3:0];
            phase    <= PH_ID;
            if (M_PRDATA[3:0] == 4'h0) begin
              seq_err  <= 1'b1;
              seq_done <= 1'b1;
              state    <= S_IDLE;
            end else begin
              state <= S_VCHK;
            end
          end
        S_VCHK:
          if (bus_done && !M_PRDATA[`AUDLK_ICS_BUSY_BIT]) state <= S_VWR;
        S_VWR:
          if (bus_done) state <= S_VGO;
        S_VGO:
          if (bus_done) begin
            tmr   <= 21'h0;
            state <= S_VPOLL;
          end
        S_VPOLL:
          if (bus_done) begin
            if (!M_PRDATA[`AUDLK_ICS_BUSY_BIT]) begin
              state <= M_PRDATA[`AUDLK_ICS_VALID_BIT] ? S_VRESP : S_VNEXT;
            end else if (tmr >= `AUDLK_ICB_CYC) begin
              seq_err <= 1'b1;
              state   <= S_VCLR;
            end
          end
        S_VCLR:
          if (bus_done) state <= S_VNEXT;
        S_VRESP:
          if (bus_done) begin
            resp_reg <= M_PRDATA;
            resp_ok  <= 1'b1;
            if (phase == PH_ID) vid_reg <= M_PRDATA;
            state <= S_VNEXT;
          end
        // Identity match opens the table, sent word by word
        S_VNEXT: begin
          state <= S_IDLE;
          if (phase == PH_ID) begin
            if (vid_reg == exp_id && tbl_len != 5'h0) begin
              phase   <= PH_TBL;
              tbl_idx <= 4'h0;
              state   <= S_VCHK;
            end else begin
              id_miss  <= (vid_reg != exp_id);
              seq_done <= 1'b1;
            end
          end else if (phase == PH_TBL && ({1'b0, tbl_idx} + 5'h1) != tbl_len) begin
            tbl_idx <= tbl_idx + 4'h1;
            state   <= S_VCHK;
          end else begin
            seq_done <= 1'b1;
          end
        end
        S_PDOWN:
          if (bus_done) state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
      if (wr_ctrl && S_PWDATA[0]) start_p <= 1'b1;
      if (wr_ctrl && S_PWDATA[1]) verb_p <= 1'b1;
      if (pwr_rise) pwr_up_p <= 1'b1;
      if (pwr_fall) pwr_dn_p <= 1'b1;
    end
  end

  // ==========================================================================
  // Software register writes; every register, table included, only while idle to keep verbs stable
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_cfg <= `AUDLK_CTRL_RESET;
      verb_reg <= 32'h0;
      exp_id   <= 32'h0;
      tbl_len  <= 5'h0;
      for (i = 0; i < `AUDLK_TBL_DEPTH; i = i + 1)
        tbl[i] <= 32'h0;
    end else if (sw_wr && state == S_IDLE) begin
      case (S_PADDR)
        `AUDLK_R_CTRL:  ctrl_cfg <= S_PWDATA & `AUDLK_CTRL_MASK;
        `AUDLK_R_VERB:  verb_reg <= S_PWDATA;
        `AUDLK_R_EXPID: exp_id   <= S_PWDATA;
        `AUDLK_R_TLEN:  tbl_len  <= (S_PWDATA[4:0] > 5'h10) ? 5'h10 : S_PWDATA[4:0];
        default: begin
          if (S_PADDR[7:6] == 2'b01)
            tbl[S_PADDR[5:2]] <= S_PWDATA;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read mux; unmapped addresses read zero with an error
  always @* begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    case (S_PADDR)
      `AUDLK_R_CTRL:  rd_mux = ctrl_cfg;
      `AUDLK_R_STAT:  rd_mux = {11'h0, state, 3'h0, link_seen, presence, 3'h0,
                                id_miss, resp_ok, seq_err, seq_done,
                                (state != S_IDLE)};
      `AUDLK_R_VERB:  rd_mux = verb_reg;
      `AUDLK_R_RESP:  rd_mux = resp_reg;
      `AUDLK_R_VID:   rd_mux = vid_reg;
      `AUDLK_R_EXPID: rd_mux = exp_id;
      `AUDLK_R_TLEN:  rd_mux = {27'h0, tbl_len};
      default: begin
        if (S_PADDR[7:6] == 2'b01 && S_PADDR[1:0] == 2'b00)
          rd_mux = tbl[S_PADDR[5:2]];
        else
          rd_err = 1'b1;
      end
    endcase
  end

  // Answer is loaded in setup so it stands through the access cycle
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      S_PRDATA  <= 32'h0;
      S_PSLVERR <= 1'b0;
    end else if (sw_setup) begin
      S_PRDATA  <= S_PWRITE ? 32'h0 : rd_mux;
      S_PSLVERR <= rd_err;
    end
  end

endmodule // audlk_host

// ===== test/audlk_dev.sv
`timescale 1ns/100ps
`include "audlk_defines.vh"
// ======================================
// Device model
module audlk_dev #(
  parameter [31:0] ID_CODE = 32'h5a0c1e37, // Arbitrary identity value
  parameter [3:0]  PRESENT = 4'h4
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        slow,
  input  wire        stuck,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [23:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready
);
  reg  [31:0] freq, pinb, link_ctl, ext_mode, cmd, resp, rd;
  reg         run, busy, valid, asleep, wt;
  reg  [7:0]  bcnt, scnt;
  wire [19:0] ix = paddr[21:2];
  // Slow mode adds one wait state to every access
  assign pready = psel & penable & (wt | ~slow);
  // A released bus shows the inverse, never the last good word
  assign prdata = pready ? rd : ~rd;
  // Read mux; only places the host reads back
  always @* begin
    case (ix)
      `AUDLK_GCTL_IDX: rd = {31'h0, run};
      `AUDLK_PRES_IDX: rd = {28'h0, asleep ? 4'h0 : PRESENT};
      `AUDLK_IR_IDX:   rd = resp;
      `AUDLK_ICS_IDX:  rd = {30'h0, valid, busy};
      `AUDLK_WAKE_IDX: rd = {17'h0, asleep, 14'h0};
      default:         rd = 32'h0;
    endcase
  end
  // Writes, command engine and wake timer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {freq, pinb, link_ctl, ext_mode, cmd, resp} <= 192'h0;
      {run, busy, valid, wt} <= 4'h0;
      asleep <= 1'b1;
      {bcnt, scnt} <= 16'h0;
    end else begin
      wt <= psel & penable & ~wt;
      bcnt <= (bcnt != 8'h0) ? bcnt - 8'h1 : 8'h0;
      scnt <= (scnt != 8'h0) ? scnt - 8'h1 : 8'h0;
      // A stuck codec never finishes, so the host must force idle
      if (bcnt == 8'h1 && !stuck) begin
        busy <= 1'b0;
        valid <= 1'b1;
        resp <= (cmd == {4'h2, `AUDLK_GETID_LOW}) ? ID_CODE : ~cmd;
      end
      if (scnt == 8'h1) asleep <= 1'b0;
      if (pready && pwrite) begin
        case (ix)
          `AUDLK_GCTL_IDX: run <= pwdata[0];
          `AUDLK_IC_IDX:   cmd <= pwdata;
          `AUDLK_ICS_IDX: begin
            if (pwdata[1:0] == 2'h3) begin
              busy <= 1'b1;
              valid <= 1'b0;
              bcnt <= 8'd12;
            end else begin
              busy <= busy & pwdata[0];
              valid <= valid & ~pwdata[1];
            end
          end
          `AUDLK_WAKE_IDX: if (pwdata[15] && run) scnt <= 8'd20;
          `AUDLK_FREQ_IDX: freq <= pwdata;
          `AUDLK_PINB_IDX: pinb <= pwdata;
          `AUDLK_CONTROLLER_LINK_CONTROL_IDX: link_ctl <= pwdata;
          `AUDLK_EM1_IDX:  ext_mode <= pwdata;
          default: ;
        endcase
      end
    end
  end
endmodule // audlk_dev

// ===== test/audlk_host_properties.sv
`timescale 1ns/100ps
`include "audlk_defines.vh"
// ======================================
// Device-side master checks
module audlk_host_chk #(
  parameter [20:0] WAKE_WAIT_CYC = 21'd50
) (
  input wire        CLOCK,
  input wire        RSTN,
  input wire        CODEC_POWER_ON,
  input wire        M_PSEL,
  input wire        M_PENABLE,
  input wire        M_PWRITE,
  input wire [23:0] M_PADDR,
  input wire [31:0] M_PWDATA,
  input wire [31:0] M_PRDATA,
  input wire        M_PREADY
);
  wire        fin = M_PSEL & M_PENABLE & M_PREADY;
  wire        wr  = fin & M_PWRITE;
  wire [19:0] ix  = M_PADDR[21:2];
  reg         freq_seen;
  reg         ics_busy;
  reg  [20:0] wake_cnt;
  // History of the master; wake count keeps two cycles of slack
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      freq_seen <= 1'b0;
      ics_busy <= 1'b0;
      wake_cnt <= 21'h0;
    end else begin
      // Each pin buffer write with bit 31 set needs a fresh link-settings write before it
      if (wr && ix == `AUDLK_FREQ_IDX) freq_seen <= 1'b1;
      else if (wr && ix == `AUDLK_PINB_IDX) freq_seen <= 1'b0;
      if (fin && ix == `AUDLK_ICS_IDX)
        ics_busy <= M_PWRITE ? (M_PWDATA == `AUDLK_ICS_LAUNCH) : M_PRDATA[0];
      if (wr && ix == `AUDLK_WAKE_IDX) wake_cnt <= WAKE_WAIT_CYC - 21'h2;
      else if (wake_cnt != 21'h0) wake_cnt <= wake_cnt - 21'h1;
    end
  end
  chk_req_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    M_PSEL && !(M_PENABLE && M_PREADY) |=> M_PSEL && M_PENABLE && $stable(M_PADDR)
      && $stable(M_PWDATA) && $stable(M_PWRITE)) else $error("request changed early");
  chk_idle_gap: assert property (@(posedge CLOCK) disable iff (!RSTN)
    fin |=> !M_PSEL) else $error("no idle cycle between transfers");
  chk_mode_pair: assert property (@(posedge CLOCK) disable iff (!RSTN)
    wr && ix == `AUDLK_FREQ_IDX |->
      (M_PWDATA[15:14] == `AUDLK_TMODE_8T && M_PWDATA[12:11] == `AUDLK_PULL_LATER) ||
      (M_PWDATA[15:14] == `AUDLK_TMODE_4T && M_PWDATA[12:11] == `AUDLK_PULL_FIRST))
    else $error("mode and pull-in do not pair");
  chk_pin_order: assert property (@(posedge CLOCK) disable iff (!RSTN)
    wr && ix == `AUDLK_PINB_IDX && M_PWDATA[31] |-> freq_seen)
    else $error("pin buffer before link settings");
  chk_wake_wait: assert property (@(posedge CLOCK) disable iff (!RSTN)
    M_PSEL && !M_PENABLE |-> wake_cnt == 21'h0) else $error("access during wake wait");
  chk_busy_first: assert property (@(posedge CLOCK) disable iff (!RSTN)
    wr && ix == `AUDLK_IC_IDX |-> !ics_busy) else $error("command written while busy");
  chk_power_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $fell(CODEC_POWER_ON) |-> ##[1:60]
      wr && ix == `AUDLK_PINB_IDX && M_PWDATA == `AUDLK_PINB_OFF)
    else $error("pin buffer not cleared");
  chk_power_on: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(CODEC_POWER_ON) |-> ##[1:60] wr && ix == `AUDLK_FREQ_IDX)
    else $error("link settings not rewritten");
endmodule // audlk_host_chk

bind audlk_host audlk_host_chk #(.WAKE_WAIT_CYC(WAKE_WAIT_CYC)) audlk_host_chk_inst (.*);

// ===== test/tb_audlk_host.sv
`timescale 1ns/100ps
`include "audlk_defines.vh"
// ======================================
// Bench
module tb_audlk_host;
  localparam [31:0] ID = 32'h5a0c1e37; // Arbitrary identity value
  localparam [31:0] VB = 32'h20471c10;
  logic        CLOCK, RSTN, LINK_BCLK, CODEC_POWER_ON, S_PSEL, S_PENABLE, S_PWRITE;
  logic [7:0]  S_PADDR;
  logic [31:0] S_PWDATA, S_PRDATA, M_PWDATA, M_PRDATA, rdv;
  logic        S_PREADY, S_PSLVERR, M_PSEL, M_PENABLE, M_PWRITE, M_PREADY, errv, slow, stuck;
  logic [23:0] M_PADDR;
  logic [31:0] vq[$];
  int          errors = 0, checks = 0, cyc = 0, nfreq = 0;
  audlk_host #(.WAKE_WAIT_CYC(21'd50), .SLEEP_TMO_CYC(21'd300)) audlk_host_inst (.*);
  audlk_dev #(.ID_CODE(ID), .PRESENT(4'h4)) audlk_dev_inst (
    .clk(CLOCK), .rst_n(RSTN), .slow(slow), .stuck(stuck), .psel(M_PSEL),
    .penable(M_PENABLE), .pwrite(M_PWRITE), .paddr(M_PADDR), .pwdata(M_PWDATA),
    .prdata(M_PRDATA), .pready(M_PREADY));
  // System and free link clocks
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  initial begin
    LINK_BCLK = 1'b0;
    #7;
    forever #160 LINK_BCLK = ~LINK_BCLK;
  end
  // Log device writes and cut a hang short
  always @(posedge CLOCK) begin
    cyc++;
    if (M_PSEL && M_PENABLE && M_PREADY && M_PWRITE) begin
      if (M_PADDR[21:2] == `AUDLK_IC_IDX) vq.push_back(M_PWDATA);
      if (M_PADDR[21:2] == `AUDLK_FREQ_IDX) nfreq++;
    end
    if (cyc == 30000) begin
      errors++;
      close_out();
    end
  end
  // ======================================
  // Shared tasks
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge CLOCK);
    S_PSEL <= 1'b1;
    S_PWRITE <= w;
    S_PADDR <= a;
    S_PWDATA <= d;
    @(posedge CLOCK);
    S_PENABLE <= 1'b1;
    do @(posedge CLOCK); while (S_PREADY !== 1'b1);
    rdv = S_PRDATA;
    errv = S_PSLVERR;
    S_PSEL <= 1'b0;
    S_PENABLE <= 1'b0;
  endtask
  task automatic chk(string nm, logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Poll status until idle with done set, at most 3000 reads
  task automatic wait_done;
    rdv = 32'h0;
    for (int n = 0; n < 3000 && rdv[1:0] !== 2'b10; n++) apb(1'b0, `AUDLK_R_STAT, 32'h0);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ======================================
  // Scenarios
  task automatic t_regs;
    apb(1'b0, `AUDLK_R_CTRL, 32'h0);
    chk("ctrl reset", `AUDLK_CTRL_RESET, rdv);
    apb(1'b1, `AUDLK_R_CTRL, 32'hfffffffc);
    apb(1'b0, `AUDLK_R_CTRL, 32'h0);
    chk("ctrl mask", `AUDLK_CTRL_MASK, rdv);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, errv);
    chk("unmapped data", 32'h0, rdv);
  endtask
  task automatic t_bringup(logic step, logic [31:0] expid, int n);
    logic [31:0] f;
    int          i, m;
    vq.delete();
    m = (expid === ID) ? n : 0;
    apb(1'b1, `AUDLK_R_EXPID, expid);
    apb(1'b1, `AUDLK_R_TLEN, 32'(n));
    for (i = 0; i < n; i++) apb(1'b1, `AUDLK_R_TBL + 8'(i * 4), VB + 32'(i));
    apb(1'b1, `AUDLK_R_CTRL, {18'h0, 4'h2, step, 5'h0, 2'h2, 2'h1});
    wait_done;
    chk("presence", 32'h4, rdv[11:8]);
    chk("error flag", 32'h0, rdv[2]);
    chk("mismatch", expid !== ID, rdv[4]);
    f = audlk_dev_inst.freq;
    chk("bclk", 32'h2, f[4:3]);
    chk("tmode", step ? `AUDLK_TMODE_8T : `AUDLK_TMODE_4T, f[15:14]);
    chk("pull-in", step ? `AUDLK_PULL_LATER : `AUDLK_PULL_FIRST, f[12:11]);
    chk("link ctl", f, audlk_dev_inst.link_ctl);
    chk("ext mode", f, audlk_dev_inst.ext_mode);
    chk("pin buffer", `AUDLK_PINB_EN, audlk_dev_inst.pinb);
    chk("run bit", 32'h1, audlk_dev_inst.run);
    apb(1'b0, `AUDLK_R_VID, 32'h0);
    chk("identity", ID, rdv);
    chk("verb count", 32'(1 + m), 32'(vq.size()));
    chk("id verb", {4'h2, `AUDLK_GETID_LOW}, vq[0]);
    for (i = 1; i <= m; i++) chk("table verb", VB + 32'(i - 1), vq[i]);
  endtask
  task automatic t_verb(logic stk);
    stuck <= stk;
    vq.delete();
    apb(1'b1, `AUDLK_R_VERB, 32'h20371c55);
    apb(1'b1, `AUDLK_R_CTRL, 32'h00000802);
    wait_done;
    chk("error flag", stk, rdv[2]);
    chk("busy left", 32'h0, audlk_dev_inst.busy);
    chk("verb sent", 32'h20371c55, vq[0]);
    apb(1'b0, `AUDLK_R_RESP, 32'h0);
    if (!stk) chk("response", ~32'h20371c55, rdv);
    stuck <= 1'b0;
  endtask
  task automatic t_power;
    int n;
    n = nfreq;
    CODEC_POWER_ON <= 1'b0;
    repeat (60) @(posedge CLOCK);
    chk("pins off", `AUDLK_PINB_OFF, audlk_dev_inst.pinb);
    CODEC_POWER_ON <= 1'b1;
    repeat (60) @(posedge CLOCK);
    chk("freq rewrite", 32'(n + 1), 32'(nfreq));
  endtask
  // Main sequence
  initial begin
    {S_PSEL, S_PENABLE, S_PWRITE, CODEC_POWER_ON, slow, stuck, S_PADDR, S_PWDATA} = 46'h0;
    RSTN = 1'b0;
    repeat (5) @(posedge CLOCK);
    RSTN <= 1'b1;
    CODEC_POWER_ON <= 1'b1;
    repeat (20) @(posedge CLOCK);
    t_regs;
    slow <= 1'b1;
    t_bringup(1'b0, ID, 3);
    slow <= 1'b0;
    t_bringup(1'b1, ~ID, 2);
    t_verb(1'b0);
    t_verb(1'b1);
    t_power;
    close_out;
  end
endmodule // tb_audlk_host
